// ### bench/copcr_regs_chk.sv
/*
 * Port relations of the configuration slice.
 * Bound to copcr_regs from the bench top; sees only its ports.
 */
`timescale 1ns/1ps
module copcr_regs_chk
	import copcr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched ports
	input wire logic regRead,
	input wire copcr_wr_s regReq,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid,
	input wire logic regAddrErr,
	input wire logic fuseLoadDone,
	input wire logic fuseLoaded,
	input wire logic outAEnable,
	input wire logic outBEnable,
	input wire logic modStepTick,
	input wire copcr_pins_s outAPins,
	input wire copcr_pins_s outBPins,
	input wire logic [2:0] outAFormat,
	input wire logic outAEdgeRateValid,
	input wire logic spreadActive,
	input wire logic [23:0] spreadNumOffset
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_read_answer: assert property (regRead |=> regRdValid)
		else $error("read not answered");
	a_bad_index: assert property (regRead && (regReq.addr < 8'h03 || regReq.addr > 8'h06)
		|=> regAddrErr && regRdData == 16'h0000) else $error("bad index not flagged");
	a_idle_quiet: assert property (!regRead |=> !regRdValid && regRdData == 16'h0000)
		else $error("read data without read");
	a_off_pins_a: assert property (!outAEnable |=> !outAPins.carryClock
		&& outAPins.forceLow == outAPins.oeP && outAPins.oeP == outAPins.oeN)
		else $error("output A disable drive wrong");
	a_off_pins_b: assert property (!outBEnable |=> !outBPins.carryClock
		&& outBPins.forceLow == outBPins.oeP && outBPins.oeP == outBPins.oeN)
		else $error("output B disable drive wrong");
	// Outputs from the reset edge itself are all zero, so skip that cycle
	a_edge_valid: assert property (!$past(rst) |-> outAEdgeRateValid == (outAFormat < 3'h4))
		else $error("edge rate validity wrong");
	a_single_pin: assert property (outAPins.carryClock && outAFormat == 3'h4
		|-> outAPins.oeP && !outAPins.oeN) else $error("single ended pin wrong");
	a_spread_zero: assert property (!spreadActive |-> spreadNumOffset == 24'h000000)
		else $error("offset while inactive");
	a_offset_hold: assert property (spreadActive && !modStepTick
		|=> !spreadActive || $stable(spreadNumOffset)) else $error("offset moved without tick");
	a_fuse_done: assert property (fuseLoadDone |=> fuseLoaded)
		else $error("fuse load not flagged");
	a_fuse_keep: assert property (fuseLoaded |=> fuseLoaded)
		else $error("fuse flag dropped");
endmodule : copcr_regs_chk

// ### bench/test_copcr_regs.sv
/*
 * Self-checking bench for copcr_regs.
 * Drives every port itself; 40 MHz clock, fixed random seed.
 */
`timescale 1ns/1ps
module test_copcr_regs import copcr_pkg::*;;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic fuseWrite = 1'b0;
	logic fuseLoadDone = 1'b0;
	logic outAEnable = 1'b0;
	logic outBEnable = 1'b0;
	logic modStepTick = 1'b0;
	copcr_wr_s regReq = '0;
	copcr_wr_s fuseReq = '0;
	logic [15:0] regRdData;
	logic regRdValid, regAddrErr, fuseLoaded, outAEdgeRateValid, spreadActive;
	copcr_route_s route;
	copcr_pins_s outAPins, outBPins;
	logic [2:0] outAFormat;
	logic [1:0] outAEdgeRate;
	logic [7:0] fracDivBNumeratorHigh;
	logic [23:0] spreadNumOffset;
	int error_cnt = 0;
	int num_checks = 0;
	logic [5:0] ratio [8] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h14, 6'h28};

	always #12.5 clock = ~clock;

	copcr_regs i_dut (.clock, .rst, .regWrite, .regRead, .regReq, .regRdData, .regRdValid,
		.regAddrErr, .fuseWrite, .fuseReq, .fuseLoadDone, .fuseLoaded, .outAEnable,
		.outBEnable, .modStepTick, .route, .outAPins, .outBPins, .outAFormat, .outAEdgeRate,
		.outAEdgeRateValid, .fracDivBNumeratorHigh, .spreadActive, .spreadNumOffset);

	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task complete_run;
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regReq <= {a, d};
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	// Flags bad index itself, so callers give only the word
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		regRead <= 1'b1;
		regReq <= {a, 16'h0000};
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk(regRdData, e);
		chk(regRdValid, 1'b1);
		chk(regAddrErr, a < 8'h03 || a > 8'h06);
	endtask : rd

	task settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle

	task tick;
		@(posedge clock);
		modStepTick <= 1'b1;
		@(posedge clock);
		modStepTick <= 1'b0;
		#1;
	endtask : tick

	function automatic copcr_pins_s pinx(logic en, logic off, logic [2:0] f);
		if (en)
			return {1'b1, 1'b0, f != 3'h5, f != 3'h4};
		return off ? 4'h0 : 4'h7;
	endfunction : pinx

	// Triangle model: center starts upward on a half-length leg
	task spread_run(input logic ty, input logic [12:0] n, input logic [15:0] s);
		logic [23:0] o;
		logic up;
		int k, lim;
		o = '0;
		up = ty;
		k = 0;
		lim = ty ? n >> 1 : n;
		wr(8'h05, s);
		wr(8'h04, {1'b0, n, ty, 1'b1});
		settle;
		chk(spreadActive, 1'b1);
		repeat (14)
		begin
			repeat ($urandom % 3) @(posedge clock);
			tick;
			o = up ? o + s : o - s;
			k++;
			if (k >= lim)
			begin
				up = !up;
				k = 0;
				lim = n;
			end
			chk(spreadNumOffset, o);
		end
		wr(8'h04, {1'b0, n, ty, 1'b0});
		settle;
		tick;
		chk(spreadActive, 1'b0);
		chk(spreadNumOffset, 24'h000000);
	endtask : spread_run

	initial
	begin
		#500000;
		error_cnt++;
		complete_run;
	end

	initial
	begin
		logic [15:0] d;
		logic offA;
		void'($urandom(86));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		settle;
		rd(8'h03, 16'h0001);
		rd(8'h04, 16'h0000);
		rd(8'h05, 16'h0000);
		rd(8'h06, 16'h0aa0);
		rd(8'h07, 16'h0000);
		rd(8'h02, 16'h0000);
		chk(route.chan0Ratio, 6'h02);
		chk(fracDivBNumeratorHigh, 8'h55);
		for (int c = 0; c < 8; c++)
		begin
			d = 16'($urandom);
			d[2:0] = 3'(c);
			d[3] = (c == 0);
			d[7] = (c == 1);
			wr(8'h03, d);
			outAEnable <= c[0];
			outBEnable <= c[1];
			settle;
			chk(route.chan0Ratio, ratio[c]);
			chk(route.outASource, d[3]);
			chk(route.outBSource, d[7]);
			chk(route.chan0DividerSource, d[4]);
			chk(outAPins, pinx(c[0], d[5], 3'h0));
			chk(outBPins, pinx(c[1], d[6], 3'h0));
			rd(8'h03, {8'h00, d[7:0]});
		end
		offA = d[5];
		for (int c = 0; c < 8; c++)
		begin
			d = 16'($urandom);
			d[15:13] = 3'(c);
			d[2:0] = 3'(c);
			wr(8'h06, d);
			settle;
			chk(route.chan1Ratio, ratio[c]);
			chk(fracDivBNumeratorHigh, d[12:5]);
			chk(outAFormat, d[2:0]);
			chk(outAEdgeRate, d[4:3]);
			chk(outAEdgeRateValid, c < 4);
			chk(outAPins, pinx(outAEnable, offA, d[2:0]));
			rd(8'h06, d);
		end
		wr(8'h04, 16'h7ffe);
		rd(8'h04, 16'h7ffe);
		spread_run(1'b0, 13'h0002, 16'($urandom));
		spread_run(1'b1, 13'h0004, 16'($urandom));
		@(posedge clock);
		regWrite <= 1'b1;
		fuseWrite <= 1'b1;
		fuseLoadDone <= 1'b1;
		regReq <= {8'h05, 16'h1111};
		fuseReq <= {8'h05, 16'h2222};
		@(posedge clock);
		regWrite <= 1'b0;
		fuseWrite <= 1'b0;
		fuseLoadDone <= 1'b0;
		settle;
		chk(fuseLoaded, 1'b1);
		rd(8'h05, 16'h2222);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		settle;
		chk(fuseLoaded, 1'b0);
		rd(8'h06, 16'h0aa0);
		complete_run;
	end
endmodule : test_copcr_regs

bind copcr_regs copcr_regs_chk i_chk (.clock, .rst, .regRead, .regReq, .regRdData,
	.regRdValid, .regAddrErr, .fuseLoadDone, .fuseLoaded, .outAEnable, .outBEnable,
	.modStepTick, .outAPins, .outBPins, .outAFormat, .outAEdgeRateValid, .spreadActive,
	.spreadNumOffset);

// ### inc/copcr_cfg.svh
/*
 * Offsets, field positions, reset values and code figures of the
 * clock output path configuration slice.
 * Assumes an eight-bit register index and sixteen-bit register words.
 */
`ifndef COPCR_CFG_SVH
`define COPCR_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define COPCR_OFS_PATH_SEL 8'h03
`define COPCR_OFS_SPREAD_CTRL 8'h04
`define COPCR_OFS_SPREAD_INC 8'h05
`define COPCR_OFS_CH1_FMT 8'h06

// ----------------------------------------
// Reset values
// ----------------------------------------
`define COPCR_RST_PATH_SEL 8'h01
`define COPCR_RST_SPREAD_CTRL 16'h0000
`define COPCR_RST_SPREAD_INC 16'h0000
`define COPCR_RST_CH1_FMT 16'h0aa0

// ----------------------------------------
// Path select fields (low byte of its register)
// ----------------------------------------
`define COPCR_CH1_COMB_BIT 7
`define COPCR_OUTB_OFF_BIT 6
`define COPCR_OUTA_OFF_BIT 5
`define COPCR_CH0_SRC_BIT 4
`define COPCR_CH0_COMB_BIT 3
`define COPCR_CHAN0_DIVIDE_CODE_MSB 2
`define COPCR_CHAN0_DIVIDE_CODE_LSB 0

// ----------------------------------------
// Spread control and output format fields
// ----------------------------------------
`define COPCR_SPREAD_RSVD_BIT 15
`define COPCR_STEPS_MSB 14
`define COPCR_STEPS_LSB 2
`define COPCR_MODTYPE_BIT 1
`define COPCR_SPREAD_EN_BIT 0
`define COPCR_CHAN1_DIVIDE_CODE_MSB 15
`define COPCR_CHAN1_DIVIDE_CODE_LSB 13
`define COPCR_NUMB_HI_MSB 12
`define COPCR_NUMB_HI_LSB 5
`define COPCR_EDGE_MSB 4
`define COPCR_EDGE_LSB 3
`define COPCR_FMT_MSB 2
`define COPCR_FMT_LSB 0

// ----------------------------------------
// Divide ratios for codes 1..7, and single-ended pin codes
// ----------------------------------------
`define COPCR_DIV_1 6'h02
`define COPCR_DIV_2 6'h04
`define COPCR_DIV_3 6'h06
`define COPCR_DIV_4 6'h08
`define COPCR_DIV_5 6'h0a
`define COPCR_DIV_6 6'h14
`define COPCR_DIV_7 6'h28
`define COPCR_FMT_SE_P_ONLY 3'h4
`define COPCR_FMT_SE_N_ONLY 3'h5

`endif

// ### inc/copcr_pkg.sv
/*
 * Types shared by the clock output path configuration slice.
 * Assumes copcr_cfg.svh supplies every figure.
 */
package copcr_pkg;

	typedef enum logic {COPCR_SRC_CHAN_DIV, COPCR_SRC_COMBINER} copcr_drv_src_e;
	typedef enum logic {COPCR_FOD_A, COPCR_FOD_B} copcr_fod_e;
	typedef enum logic {COPCR_SPREAD_DOWN, COPCR_SPREAD_CENTER} copcr_spread_e;

	// One register access from the serial port or the fuse loader
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} copcr_wr_s;

	// Pin drive of one output driver
	typedef struct packed {
		logic carryClock;
		logic forceLow;
		logic oeP;
		logic oeN;
	} copcr_pins_s;

	// Clock routing decided by the slice
	typedef struct packed {
		copcr_drv_src_e outASource;
		copcr_drv_src_e outBSource;
		copcr_fod_e chan0DividerSource;
		logic [5:0] chan0Ratio;
		logic [5:0] chan1Ratio;
	} copcr_route_s;

endpackage : copcr_pkg

// ### src/copcr_regs.sv
/*
 * Configuration register slice of a programmable clock generator:
 * output path select, spread-spectrum control and step, channel 1
 * divider with output A format. Also runs the triangular spread
 * modulator on the numerator offset.
 * Assumes the serial management port and the fuse loader hand over
 * decoded word accesses on this clock, and that output enables and
 * the step tick come from logic on the same clock.
 */
`timescale 1ns/1ps

`include "copcr_cfg.svh"

module copcr_regs
	import copcr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Serial port register access
	input wire logic regWrite,
	input wire logic regRead,
	input wire copcr_wr_s regReq,
	output logic [15:0] regRdData,
	output logic regRdValid,
	output logic regAddrErr,
	// Fuse page load at start-up
	input wire logic fuseWrite,
	input wire copcr_wr_s fuseReq,
	input wire logic fuseLoadDone,
	output logic fuseLoaded,
	// Output enables from the neighbouring register
	input wire logic outAEnable,
	input wire logic outBEnable,
	// Modulation step timing
	input wire logic modStepTick,
	// Clock routing and driver control
	output copcr_route_s route,
	output copcr_pins_s outAPins,
	output copcr_pins_s outBPins,
	output logic [2:0] outAFormat,
	output logic [1:0] outAEdgeRate,
	output logic outAEdgeRateValid,
	output logic [7:0] fracDivBNumeratorHigh,
	// Spread modulation state
	output logic spreadActive,
	output logic [23:0] spreadNumOffset
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [5:0] divRatio(input logic [2:0] code);
		logic [5:0] r;
		r = 6'h00;
		case (code)
			3'h1: r = `COPCR_DIV_1;
			3'h2: r = `COPCR_DIV_2;
			3'h3: r = `COPCR_DIV_3;
			3'h4: r = `COPCR_DIV_4;
			3'h5: r = `COPCR_DIV_5;
			3'h6: r = `COPCR_DIV_6;
			3'h7: r = `COPCR_DIV_7;
			default: r = 6'h00;
		endcase
		return r;
	endfunction : divRatio

	function automatic copcr_pins_s pinDrive(input logic en, input logic offHiZ,
		input logic [2:0] fmt);
		copcr_pins_s p;
		p = '0;
		if (en)
		begin
			p.carryClock = 1'b1;
			p.oeP = (fmt != `COPCR_FMT_SE_N_ONLY);
			p.oeN = (fmt != `COPCR_FMT_SE_P_ONLY);
		end
		else if (!offHiZ)
		begin
			p.forceLow = 1'b1;
			p.oeP = 1'b1;
			p.oeN = 1'b1;
		end
		return p;
	endfunction : pinDrive

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] pathSel_reg;
	logic [15:0] spreadCtrl_reg;
	logic [15:0] spreadInc_reg;
	logic [15:0] ch1Fmt_reg;
	logic fuseLoaded_reg;

	// Fuse loader owns the port while it writes; a software write in the same cycle is dropped
	logic wrEn;
	copcr_wr_s wrReq;
	assign wrEn = fuseWrite | regWrite;
	assign wrReq = fuseWrite ? fuseReq : regReq;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pathSel_reg <= `COPCR_RST_PATH_SEL;
			spreadCtrl_reg <= `COPCR_RST_SPREAD_CTRL;
			spreadInc_reg <= `COPCR_RST_SPREAD_INC;
			ch1Fmt_reg <= `COPCR_RST_CH1_FMT;
		end
		else if (wrEn)
		begin
			if (wrReq.addr == `COPCR_OFS_PATH_SEL)
				pathSel_reg <= wrReq.data[7:0];
			else if (wrReq.addr == `COPCR_OFS_SPREAD_CTRL)
			begin
				spreadCtrl_reg <= wrReq.data;
				spreadCtrl_reg[`COPCR_SPREAD_RSVD_BIT] <= 1'b0;
			end
			else if (wrReq.addr == `COPCR_OFS_SPREAD_INC)
				spreadInc_reg <= wrReq.data;
			else if (wrReq.addr == `COPCR_OFS_CH1_FMT)
				ch1Fmt_reg <= wrReq.data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			fuseLoaded_reg <= 1'b0;
		else if (fuseLoadDone)
			fuseLoaded_reg <= 1'b1;
	end
	assign fuseLoaded = fuseLoaded_reg;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [15:0] regRdData_reg;
	logic regRdValid_reg;
	logic regAddrErr_reg;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			regRdData_reg <= 16'h0000;
			regRdValid_reg <= 1'b0;
			regAddrErr_reg <= 1'b0;
		end
		else
		begin
			regRdValid_reg <= regRead;
			regAddrErr_reg <= 1'b0;
			if (!regRead)
				regRdData_reg <= 16'h0000;
			else if (regReq.addr == `COPCR_OFS_PATH_SEL)
				regRdData_reg <= {8'h00, pathSel_reg};
			else if (regReq.addr == `COPCR_OFS_SPREAD_CTRL)
				regRdData_reg <= spreadCtrl_reg;
			else if (regReq.addr == `COPCR_OFS_SPREAD_INC)
				regRdData_reg <= spreadInc_reg;
			else if (regReq.addr == `COPCR_OFS_CH1_FMT)
				regRdData_reg <= ch1Fmt_reg;
			else
			begin
				// Outside this slice: answer zero and flag it
				regRdData_reg <= 16'h0000;
				regAddrErr_reg <= 1'b1;
			end
		end
	end
	assign regRdData = regRdData_reg;
	assign regRdValid = regRdValid_reg;
	assign regAddrErr = regAddrErr_reg;

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	logic chan1CombinerSelect;
	logic outBOffPinState;
	logic outAOffPinState;
	logic chan0DividerSource;
	logic chan0CombinerSelect;
	logic [2:0] chan0DivideCode;
	logic [2:0] chan1DivideCode;
	logic [12:0] spreadStepCount;
	logic spreadModulationType;
	logic spreadEnable;
	logic [2:0] outAFormatField;

	assign chan1CombinerSelect = pathSel_reg[`COPCR_CH1_COMB_BIT];
	assign outBOffPinState = pathSel_reg[`COPCR_OUTB_OFF_BIT];
	assign outAOffPinState = pathSel_reg[`COPCR_OUTA_OFF_BIT];
	assign chan0DividerSource = pathSel_reg[`COPCR_CH0_SRC_BIT];
	assign chan0CombinerSelect = pathSel_reg[`COPCR_CH0_COMB_BIT];
	assign chan0DivideCode = pathSel_reg[`COPCR_CHAN0_DIVIDE_CODE_MSB:`COPCR_CHAN0_DIVIDE_CODE_LSB];
	assign chan1DivideCode = ch1Fmt_reg[`COPCR_CHAN1_DIVIDE_CODE_MSB:`COPCR_CHAN1_DIVIDE_CODE_LSB];
	assign spreadStepCount = spreadCtrl_reg[`COPCR_STEPS_MSB:`COPCR_STEPS_LSB];
	assign spreadModulationType = spreadCtrl_reg[`COPCR_MODTYPE_BIT];
	assign spreadEnable = spreadCtrl_reg[`COPCR_SPREAD_EN_BIT];
	assign outAFormatField = ch1Fmt_reg[`COPCR_FMT_MSB:`COPCR_FMT_LSB];

	// ----------------------------------------
	// Routing and driver control
	// ----------------------------------------
	copcr_route_s route_reg;
	copcr_pins_s outAPins_reg;
	copcr_pins_s outBPins_reg;
	logic [2:0] outAFormat_reg;
	logic [1:0] outAEdgeRate_reg;
	logic outAEdgeRateValid_reg;
	logic [7:0] fracDivBNumeratorHigh_reg;

	// Divider codes pass through unchanged; a nonzero code beside the
	// combiner is a software slip and is not masked here.
	always_ff @(posedge clock)
	begin
		if (rst)
			route_reg <= '0;
		else
		begin
			route_reg.outASource <= chan0CombinerSelect ?
				COPCR_SRC_COMBINER : COPCR_SRC_CHAN_DIV;
			route_reg.outBSource <= chan1CombinerSelect ?
				COPCR_SRC_COMBINER : COPCR_SRC_CHAN_DIV;
			route_reg.chan0DividerSource <= chan0DividerSource ?
				COPCR_FOD_B : COPCR_FOD_A;
			route_reg.chan0Ratio <= divRatio(chan0DivideCode);
			route_reg.chan1Ratio <= divRatio(chan1DivideCode);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			outAPins_reg <= '0;
			outBPins_reg <= '0;
		end
		else
		begin
			outAPins_reg <= pinDrive(outAEnable, outAOffPinState, outAFormatField);
			outBPins_reg <= pinDrive(outBEnable, outBOffPinState, 3'h0);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			outAFormat_reg <= 3'h0;
			outAEdgeRate_reg <= 2'h0;
			outAEdgeRateValid_reg <= 1'b0;
			fracDivBNumeratorHigh_reg <= 8'h00;
		end
		else
		begin
			outAFormat_reg <= outAFormatField;
			outAEdgeRate_reg <= ch1Fmt_reg[`COPCR_EDGE_MSB:`COPCR_EDGE_LSB];
			outAEdgeRateValid_reg <= ~outAFormatField[2];
			fracDivBNumeratorHigh_reg <=
				ch1Fmt_reg[`COPCR_NUMB_HI_MSB:`COPCR_NUMB_HI_LSB];
		end
	end

	assign route = route_reg;
	assign outAPins = outAPins_reg;
	assign outBPins = outBPins_reg;
	assign outAFormat = outAFormat_reg;
	assign outAEdgeRate = outAEdgeRate_reg;
	assign outAEdgeRateValid = outAEdgeRateValid_reg;
	assign fracDivBNumeratorHigh = fracDivBNumeratorHigh_reg;

	// ----------------------------------------
	// Triangular spread modulator
	// ----------------------------------------
	logic [23:0] spreadAcc_reg;
	logic [12:0] stepCnt_reg;
	logic dirDown_reg;
	logic halfSeg_reg;
	logic spreadActive_reg;
	logic [12:0] segLimit;
	logic [23:0] incWide;
	logic curDown;
	logic curHalf;

	// Type may change in the same write that sets enable, so the first
	// active cycle takes it live rather than from an idle copy
	assign curDown = spreadActive_reg ? dirDown_reg
		: (spreadModulationType == COPCR_SPREAD_DOWN);
	assign curHalf = spreadActive_reg ? halfSeg_reg
		: (spreadModulationType == COPCR_SPREAD_CENTER);
	// Center spread starts mid-range, so its first leg is half a segment
	assign segLimit = curHalf ? (spreadStepCount >> 1) : spreadStepCount;
	assign incWide = {8'h00, spreadInc_reg};

	always_ff @(posedge clock)
	begin
		if (rst || !spreadEnable || spreadStepCount == 13'h0000)
		begin
			spreadActive_reg <= 1'b0;
			spreadAcc_reg <= 24'h000000;
			stepCnt_reg <= 13'h0000;
			dirDown_reg <= 1'b0;
			halfSeg_reg <= 1'b0;
		end
		else
		begin
			spreadActive_reg <= 1'b1;
			dirDown_reg <= curDown;
			halfSeg_reg <= curHalf;
			if (modStepTick)
			begin
				spreadAcc_reg <= curDown ? spreadAcc_reg - incWide
					: spreadAcc_reg + incWide;
				if (stepCnt_reg + 13'h0001 >= segLimit)
				begin
					stepCnt_reg <= 13'h0000;
					dirDown_reg <= ~curDown;
					halfSeg_reg <= 1'b0;
				end
				else
					stepCnt_reg <= stepCnt_reg + 13'h0001;
			end
		end
	end

	assign spreadActive = spreadActive_reg;
	assign spreadNumOffset = spreadAcc_reg;

endmodule : copcr_regs
